// ### verilog/col_pkg.sv
package col_pkg;

   // ****************************************************************
   // Register bus geometry.
   // ****************************************************************
   localparam int COL_ADDR_W = 4;
   localparam int COL_DATA_W = 8;

   // ****************************************************************
   // Register offsets.
   // ****************************************************************
   localparam logic [COL_ADDR_W-1:0] COL_OFS_SYNC_GATE = 4'h0;
   localparam logic [COL_ADDR_W-1:0] COL_OFS_LATCH_CTRL = 4'h1;

   // ****************************************************************
   // Synchronised gate control register fields.
   // ****************************************************************
   localparam int COL_SG_MIRROR1 = 7;
   localparam int COL_SG_MIRROR2 = 6;
   localparam int COL_SG_REF1 = 5;
   localparam int COL_SG_REF2 = 4;
   localparam int COL_SG_GATE_SEL = 1;
   localparam int COL_SG_SYNC_EN = 0;
   localparam logic [COL_DATA_W-1:0] COL_SG_RESET = 8'h02;
   localparam logic [COL_DATA_W-1:0] COL_SG_WMASK = 8'h33;

   // ****************************************************************
   // Latch control register fields.
   // ****************************************************************
   localparam int COL_LC_SEL_HI = 7;
   localparam int COL_LC_SEL_LO = 6;
   localparam int COL_LC_SET_EN = 5;
   localparam int COL_LC_RST_EN = 4;
   localparam int COL_LC_SET_PULSE = 3;
   localparam int COL_LC_RST_PULSE = 2;
   localparam int COL_LC_FIXED_REF = 0;
   localparam logic [COL_DATA_W-1:0] COL_LC_RESET = 8'h00;
   localparam logic [COL_DATA_W-1:0] COL_LC_WMASK = 8'hf1;

   // ****************************************************************
   // Output multiplexer selections.
   // ****************************************************************
   localparam logic [1:0] COL_SEL_COMPARATORS = 2'h0;

   // ****************************************************************
   // Synchroniser depth for pins and foreign clocks.
   // ****************************************************************
   localparam int COL_SYNC_STAGES = 2;

endpackage

// ### verilog/col_sr_latch.sv
`timescale 1ns/1ps

module col_sr_latch (
   // Clock, reset and enable.
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // Latch inputs, both active high.
   input wire logic setIn,
   input wire logic resetIn,
   // Latch state.
   output logic q
);
   import col_pkg::*;

   logic q_ff;

   // The element follows input levels; a reset level always beats a set level.
   always_ff @(posedge clk) begin
      if (rst) begin
         q_ff <= 1'b0;
      end else if (ce) begin
         if (resetIn) begin
            q_ff <= 1'b0;
         end else if (setIn) begin
            q_ff <= 1'b1;
         end
      end
   end

   assign q = q_ff;

   a_reset_dominant: assert property (@(posedge clk) disable iff (rst)
      (ce && resetIn) |=> !q_ff)
      else $error("latch not reset while reset input high");

   a_latch_set_hold: assert property (@(posedge clk) disable iff (rst)
      (ce && setIn && !resetIn) |=> q_ff)
      else $error("latch not set by lone set input");

   c_latch_set: cover property (@(posedge clk) disable iff (rst) !q_ff ##1 q_ff);

endmodule

// ### verilog/col_comparator_logic.sv
// The plain strobed port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps

module col_comparator_logic #(
   parameter int SYNC_STAGES = col_pkg::COL_SYNC_STAGES
) (
   // Clock, reset and enable.
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // Register port.
   input wire logic [col_pkg::COL_ADDR_W-1:0] addr,
   input wire logic [col_pkg::COL_DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [col_pkg::COL_DATA_W-1:0] rdata,
   // Comparator outputs and pins from outside the clock domain.
   input wire logic firstComparatorOutput,
   input wire logic secondComparatorOutput,
   input wire logic externalTimerGatePin,
   input wire logic prescaledTimerClock,
   // Timer control levels from the timer block.
   input wire logic timerOn,
   input wire logic timerGateEnable,
   // Port control levels.
   input wire logic portDirectionBit1,
   input wire logic portDirectionBit2,
   input wire logic comparatorPinOutputEnable1,
   input wire logic comparatorPinOutputEnable2,
   // Timer side results.
   output logic timerGateSource,
   output logic timerCountEnable,
   output logic timerIncrement,
   output logic synchronizedSecondComparatorOutput,
   // Reference routing.
   output logic firstComparatorReferenceSelect,
   output logic secondComparatorReferenceSelect,
   output logic fixedReferenceEnable,
   // Comparator output pins; enables are low while driving.
   output logic pinOut1,
   output logic pinOut2,
   output logic pinOeN1,
   output logic pinOeN2,
   // Latch state.
   output logic latchQ
);
   import col_pkg::*;

   // A chain shorter than two stages would let a metastable level reach logic.
   if (SYNC_STAGES < 2) begin : g_bad_stages
      $error("SYNC_STAGES must be at least 2");
   end

   // ****************************************************************
   // Input synchronisers.
   // ****************************************************************
   localparam int NUM_SYNC = 4;

   logic [NUM_SYNC-1:0] asyncIn;
   logic [NUM_SYNC-1:0] syncOut;

   assign asyncIn = {prescaledTimerClock, externalTimerGatePin,
                     secondComparatorOutput, firstComparatorOutput};

   // Each input gets its own chain; only the last stage is read by logic.
   genvar gi;
   generate
      for (gi = 0; gi < NUM_SYNC; gi++) begin : g_sync
         logic [SYNC_STAGES-1:0] chain_ff;
         always_ff @(posedge clk) begin
            if (rst) begin
               chain_ff <= '0;
            end else if (ce) begin
               chain_ff <= {chain_ff[SYNC_STAGES-2:0], asyncIn[gi]};
            end
         end
         assign syncOut[gi] = chain_ff[SYNC_STAGES-1];
      end
   endgenerate

   logic c1Level, c2Level, gatePinLevel, tmrClkLevel;

   assign c1Level = syncOut[0];
   assign c2Level = syncOut[1];
   assign gatePinLevel = syncOut[2];
   assign tmrClkLevel = syncOut[3];

   // ****************************************************************
   // Control registers.
   // ****************************************************************
   logic [COL_DATA_W-1:0] syncGate_ff;
   logic [COL_DATA_W-1:0] latchCtrl_ff;
   logic setPulse_ff, resetPulse_ff;
   logic wrSyncGate, wrLatchCtrl;

   assign wrSyncGate = wr && (addr == COL_OFS_SYNC_GATE);
   assign wrLatchCtrl = wr && (addr == COL_OFS_LATCH_CTRL);

   // Only writable bits are stored; mirror and unused positions stay zero.
   always_ff @(posedge clk) begin
      if (rst) begin
         syncGate_ff <= COL_SG_RESET;
      end else if (ce && wrSyncGate) begin
         syncGate_ff <= wdata & COL_SG_WMASK;
      end
   end

   // The select field is stored here only, so comparator enables cannot touch it.
   always_ff @(posedge clk) begin
      if (rst) begin
         latchCtrl_ff <= COL_LC_RESET;
      end else if (ce && wrLatchCtrl) begin
         latchCtrl_ff <= wdata & COL_LC_WMASK;
      end
   end

   // A written one fires a single cycle pulse; nothing has to clear it.
   always_ff @(posedge clk) begin
      if (rst) begin
         setPulse_ff <= 1'b0;
         resetPulse_ff <= 1'b0;
      end else if (ce) begin
         setPulse_ff <= wrLatchCtrl && wdata[COL_LC_SET_PULSE];
         resetPulse_ff <= wrLatchCtrl && wdata[COL_LC_RST_PULSE];
      end
   end

   // ****************************************************************
   // Read path.
   // ****************************************************************
   logic [COL_DATA_W-1:0] nxt_rdata;
   logic [COL_DATA_W-1:0] rdata_ff;

   // Reads have no side effect, so the mismatch state outside is never disturbed.
   always_comb begin
      nxt_rdata = '0;
      if (addr == COL_OFS_SYNC_GATE) begin
         nxt_rdata = syncGate_ff;
         nxt_rdata[COL_SG_MIRROR1] = c1Level;
         nxt_rdata[COL_SG_MIRROR2] = c2Level;
      end else if (addr == COL_OFS_LATCH_CTRL) begin
         nxt_rdata = latchCtrl_ff;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rdata_ff <= '0;
      end else if (ce) begin
         rdata_ff <= rd ? nxt_rdata : '0;
      end
   end

   assign rdata = rdata_ff;

   // ****************************************************************
   // Timer clock edges and second comparator synchroniser.
   // ****************************************************************
   logic tmrClkPrev_ff;
   logic tmrFall, tmrRise;
   logic c2Captured_ff;
   logic c2SyncPath;

   // The clock seen here is already past the prescaler.
   always_ff @(posedge clk) begin
      if (rst) begin
         tmrClkPrev_ff <= 1'b0;
      end else if (ce) begin
         tmrClkPrev_ff <= tmrClkLevel;
      end
   end

   assign tmrFall = tmrClkPrev_ff && !tmrClkLevel;
   assign tmrRise = !tmrClkPrev_ff && tmrClkLevel;

   // Capturing on the falling edge keeps the value still while the timer counts.
   always_ff @(posedge clk) begin
      if (rst) begin
         c2Captured_ff <= 1'b0;
      end else if (ce && tmrFall) begin
         c2Captured_ff <= c2Level;
      end
   end

   assign c2SyncPath = syncGate_ff[COL_SG_SYNC_EN] ? c2Captured_ff : c2Level;

   // ****************************************************************
   // Timer gate and increment.
   // ****************************************************************
   logic gate_ff;
   logic countEn_ff;
   logic incr_ff;
   logic syncC2_ff;
   logic nxt_gate;
   logic nxt_countEn;

   assign nxt_gate = syncGate_ff[COL_SG_GATE_SEL] ? gatePinLevel : c2SyncPath;
   assign nxt_countEn = timerOn && (!timerGateEnable || nxt_gate);

   // Increments are issued on the rising edge only, away from the capture edge.
   always_ff @(posedge clk) begin
      if (rst) begin
         gate_ff <= 1'b0;
         countEn_ff <= 1'b0;
         incr_ff <= 1'b0;
         syncC2_ff <= 1'b0;
      end else if (ce) begin
         gate_ff <= nxt_gate;
         countEn_ff <= nxt_countEn;
         incr_ff <= tmrRise && nxt_countEn;
         syncC2_ff <= c2SyncPath;
      end
   end

   assign timerGateSource = gate_ff;
   assign timerCountEnable = countEn_ff;
   assign timerIncrement = incr_ff;
   assign synchronizedSecondComparatorOutput = syncC2_ff;

   // ****************************************************************
   // References come straight from register flops.
   // ****************************************************************
   assign firstComparatorReferenceSelect = syncGate_ff[COL_SG_REF1];
   assign secondComparatorReferenceSelect = syncGate_ff[COL_SG_REF2];
   assign fixedReferenceEnable = latchCtrl_ff[COL_LC_FIXED_REF];

   // ****************************************************************
   // Latch and output multiplexers.
   // ****************************************************************
   logic latchSet;
   logic latchReset;
   logic q;
   logic out1_ff, out2_ff, oeN1_ff, oeN2_ff;

   assign latchSet = (latchCtrl_ff[COL_LC_SET_EN] && c1Level) || setPulse_ff;
   assign latchReset = (latchCtrl_ff[COL_LC_RST_EN] && c2Level) || resetPulse_ff;

   col_sr_latch col_sr_latch_i (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .setIn(latchSet),
      .resetIn(latchReset),
      .q(q)
   );

   assign latchQ = q;

   // Low select bit swaps the first path to Q, high bit the second to inverted Q.
   always_ff @(posedge clk) begin
      if (rst) begin
         out1_ff <= 1'b0;
         out2_ff <= 1'b0;
      end else if (ce) begin
         out1_ff <= latchCtrl_ff[COL_LC_SEL_LO] ? q : c1Level;
         out2_ff <= latchCtrl_ff[COL_LC_SEL_HI] ? !q : c2Level;
      end
   end

   // A pin drives only with its direction bit clear and its enable set.
   always_ff @(posedge clk) begin
      if (rst) begin
         oeN1_ff <= 1'b1;
         oeN2_ff <= 1'b1;
      end else if (ce) begin
         oeN1_ff <= !(!portDirectionBit1 && comparatorPinOutputEnable1);
         oeN2_ff <= !(!portDirectionBit2 && comparatorPinOutputEnable2);
      end
   end

   assign pinOut1 = out1_ff;
   assign pinOut2 = out2_ff;
   assign pinOeN1 = oeN1_ff;
   assign pinOeN2 = oeN2_ff;

   // ****************************************************************
   // Checks.
   // ****************************************************************
   a_gate_source_mux: assert property (@(posedge clk) disable iff (rst)
      ce |=> (gate_ff == ($past(syncGate_ff[COL_SG_GATE_SEL]) ? $past(gatePinLevel)
                                                               : $past(c2SyncPath))))
      else $error("gate source does not follow select");
   a_count_enable_gate: assert property (@(posedge clk) disable iff (rst)
      (ce && timerOn && timerGateEnable && !nxt_gate) |=> !countEn_ff && !incr_ff)
      else $error("timer counted while gate closed");
   a_sync_holds_value: assert property (@(posedge clk) disable iff (rst)
      (ce && !tmrFall) |=> $stable(c2Captured_ff))
      else $error("captured value moved without falling edge");
   a_async_pass: assert property (@(posedge clk) disable iff (rst)
      (ce && !syncGate_ff[COL_SG_SYNC_EN]) |=> (syncC2_ff == $past(c2Level)))
      else $error("unsynchronised path not passing through");
   a_increment_rising: assert property (@(posedge clk) disable iff (rst)
      (incr_ff && $past(ce)) |-> $past(tmrRise))
      else $error("increment without rising timer edge");
   a_mirror_read: assert property (@(posedge clk) disable iff (rst)
      (ce && rd && addr == COL_OFS_SYNC_GATE) |=>
      (rdata_ff[7:6] == {$past(c1Level), $past(c2Level)}))
      else $error("mirror bits wrong");
   a_unused_zero: assert property (@(posedge clk) disable iff (rst)
      (ce && rd && addr == COL_OFS_SYNC_GATE) |=> (rdata_ff[3:2] == 2'h0))
      else $error("unused bits not zero");
   a_pulse_one_shot: assert property (@(posedge clk) disable iff (rst)
      (ce && wrLatchCtrl && wdata[COL_LC_SET_PULSE])
      ##1 (ce && !(wrLatchCtrl && wdata[COL_LC_SET_PULSE])) |=> !setPulse_ff)
      else $error("set pulse did not clear itself");
   a_pin_enable: assert property (@(posedge clk) disable iff (rst)
      (ce && portDirectionBit1) |=> oeN1_ff)
      else $error("pin driven with direction set to input");
   a_reset_default: assert property (@(posedge clk)
      ($past(rst) && !rst) |-> (latchCtrl_ff[COL_LC_SEL_HI:COL_LC_SEL_LO] == COL_SEL_COMPARATORS))
      else $error("select not defaulted after reset");

   c_sync_capture: cover property (@(posedge clk) disable iff (rst)
      syncGate_ff[COL_SG_SYNC_EN] && tmrFall);
   c_increment: cover property (@(posedge clk) disable iff (rst) incr_ff);
   c_latched_pin: cover property (@(posedge clk) disable iff (rst)
      latchCtrl_ff[7:6] == 2'h3 && !oeN1_ff);

endmodule

// ### dv/col_timer_port_model.sv
`timescale 1ns/1ps

// ****************************************************************
// Timer clock source and port pin model.
// ****************************************************************
module col_timer_port_model #(
   parameter int HALF = 4
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Timer side.
   input wire logic runClock,
   input wire logic timerIncrement,
   output logic prescaledTimerClock,
   output int incCount,
   // Port side.
   input wire logic pinOut1,
   input wire logic pinOut2,
   input wire logic pinOeN1,
   input wire logic pinOeN2,
   output logic pinLevel1,
   output logic pinLevel2
);
   int div_ff;
   int incs_ff;
   logic tClk_ff;
   logic last1_ff;
   logic last2_ff;

   // The timer clock only moves while the bench runs it, so edges are placed on purpose.
   always_ff @(posedge clk) begin
      if (rst) begin
         div_ff <= 0;
         tClk_ff <= 1'b0;
      end else if (runClock) begin
         div_ff <= (div_ff == HALF - 1) ? 0 : div_ff + 1;
         tClk_ff <= (div_ff == HALF - 1) ? ~tClk_ff : tClk_ff;
      end
   end

   // Every increment pulse is one count of the timer.
   always_ff @(posedge clk) begin
      if (rst) begin
         incs_ff <= 0;
      end else if (timerIncrement) begin
         incs_ff <= incs_ff + 1;
      end
   end

   // A released pin shows the inverse of its last driven level, so stale data never passes.
   always_ff @(posedge clk) begin
      if (rst) begin
         last1_ff <= 1'b0;
         last2_ff <= 1'b0;
      end else begin
         last1_ff <= pinOeN1 ? last1_ff : pinOut1;
         last2_ff <= pinOeN2 ? last2_ff : pinOut2;
      end
   end

   assign prescaledTimerClock = tClk_ff;
   assign incCount = incs_ff;
   assign pinLevel1 = pinOeN1 ? ~last1_ff : pinOut1;
   assign pinLevel2 = pinOeN2 ? ~last2_ff : pinOut2;
endmodule

// ### dv/col_comparator_logic_tb.sv
`timescale 1ns/1ps

`define CHK(nm, exp, got) begin checksDone++; if ((got) !== (exp)) begin badCount++; \
   $display("ERROR %s expected %0h seen %0h", nm, exp, got); end end

module col_comparator_logic_tb;
   import col_pkg::*;

   // ****************************************************************
   // Signals, instances and run control.
   // ****************************************************************
   localparam int SETTLE = COL_SYNC_STAGES + 4;
   logic clk = 1'b0, rst = 1'b1, ce = 1'b1, wr = 1'b0, rd = 1'b0, run = 1'b0;
   logic c1 = 1'b0, c2 = 1'b0, gPin = 1'b0, tOn = 1'b0, tGate = 1'b0;
   logic dir1 = 1'b1, dir2 = 1'b1, oe1 = 1'b0, oe2 = 1'b0;
   logic [COL_ADDR_W-1:0] addr = '0;
   logic [COL_DATA_W-1:0] wdata = '0;
   logic [COL_DATA_W-1:0] rdata;
   logic tClk, gateSrc, cntEn, tInc, syncC2, ref1, ref2, fixRef, p1, p2, oeN1, oeN2, q;
   logic lvl1, lvl2;
   int incs;
   int badCount = 0;
   int checksDone = 0;

   col_comparator_logic col_comparator_logic_i (.clk(clk), .rst(rst), .ce(ce), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .firstComparatorOutput(c1),
      .secondComparatorOutput(c2), .externalTimerGatePin(gPin), .prescaledTimerClock(tClk),
      .timerOn(tOn), .timerGateEnable(tGate), .portDirectionBit1(dir1),
      .portDirectionBit2(dir2), .comparatorPinOutputEnable1(oe1),
      .comparatorPinOutputEnable2(oe2), .timerGateSource(gateSrc), .timerCountEnable(cntEn),
      .timerIncrement(tInc), .synchronizedSecondComparatorOutput(syncC2),
      .firstComparatorReferenceSelect(ref1), .secondComparatorReferenceSelect(ref2),
      .fixedReferenceEnable(fixRef), .pinOut1(p1), .pinOut2(p2), .pinOeN1(oeN1),
      .pinOeN2(oeN2), .latchQ(q));

   col_timer_port_model col_timer_port_model_i (.clk(clk), .rst(rst), .runClock(run),
      .timerIncrement(tInc), .prescaledTimerClock(tClk), .incCount(incs), .pinOut1(p1),
      .pinOut2(p2), .pinOeN1(oeN1), .pinOeN2(oeN2), .pinLevel1(lvl1), .pinLevel2(lvl2));

   // A 5 ns clock.
   always #2.5 clk = ~clk;

   // ****************************************************************
   // Bus cycles and helpers.
   // ****************************************************************
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic bus_wr(input logic [COL_ADDR_W-1:0] a, input logic [COL_DATA_W-1:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   // Read data stands only in the cycle after the strobe, so it is taken just then.
   task automatic bus_rd(input logic [COL_ADDR_W-1:0] a, output logic [COL_DATA_W-1:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask

   task automatic chkRd(input logic [COL_ADDR_W-1:0] a, input logic [7:0] e, input string nm);
      logic [COL_DATA_W-1:0] d;
      bus_rd(a, d);
      `CHK(nm, e, d)
   endtask

   // Runs the timer clock until it reaches the wanted level, then stops it.
   task automatic runTo(input logic lvl);
      run <= 1'b1;
      for (int k = 0; k < 40 && tClk !== lvl; k++) tick(1);
      run <= 1'b0;
   endtask

   task automatic testDone();
      $display("Checks made %0d, mismatches %0d", checksDone, badCount);
      if (badCount == 0 && checksDone > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // ****************************************************************
   // Scenarios.
   // ****************************************************************
   task automatic t_regs();
      logic [7:0] v;
      chkRd(COL_OFS_SYNC_GATE, 8'h02, "gate control after reset");
      chkRd(COL_OFS_LATCH_CTRL, 8'h00, "latch control after reset");
      `CHK("pin one released after reset", 1'b1, oeN1)
      chkRd(4'h5, 8'h00, "unmapped read");
      bus_wr(COL_OFS_SYNC_GATE, 8'hff);
      chkRd(COL_OFS_SYNC_GATE, 8'h33, "unused bits read zero");
      for (int i = 0; i < 4; i++) begin
         v = {2'b00, i[1:0], 4'h2};
         bus_wr(COL_OFS_SYNC_GATE, v);
         tick(2);
         `CHK("first reference select", i[1], ref1)
         `CHK("second reference select", i[0], ref2)
      end
      // With the enable low the strobe must be ignored.
      ce <= 1'b0;
      bus_wr(COL_OFS_SYNC_GATE, 8'h00);
      ce <= 1'b1;
      chkRd(COL_OFS_SYNC_GATE, 8'h32, "write ignored while disabled");
   endtask

   task automatic t_mirror();
      logic [7:0] v;
      c1 <= 1'b1;
      tick(SETTLE);
      bus_rd(COL_OFS_SYNC_GATE, v);
      `CHK("mirrored outputs", 2'b10, v[7:6])
      bus_rd(COL_OFS_SYNC_GATE, v);
      `CHK("mirrored outputs reread", 2'b10, v[7:6])
      c1 <= 1'b0;
      c2 <= 1'b1;
      tick(SETTLE);
      bus_rd(COL_OFS_SYNC_GATE, v);
      `CHK("mirrored outputs swapped", 2'b01, v[7:6])
   endtask

   task automatic t_gate();
      bus_wr(COL_OFS_SYNC_GATE, 8'h02);
      for (int i = 0; i < 2; i++) begin
         gPin <= ~i[0];
         tick(SETTLE);
         `CHK("gate follows pin", ~i[0], gateSrc)
      end
      bus_wr(COL_OFS_SYNC_GATE, 8'h00);
      tOn <= 1'b1;
      tGate <= 1'b1;
      tick(SETTLE);
      `CHK("gate follows comparator", 1'b1, gateSrc)
      `CHK("count while gate open", 1'b1, cntEn)
      c2 <= 1'b0;
      tick(SETTLE);
      `CHK("unsynchronised comparator", 1'b0, syncC2)
      `CHK("no count while gate shut", 1'b0, cntEn)
      tOn <= 1'b0;
      c2 <= 1'b1;
      tick(SETTLE);
      `CHK("no count while timer off", 1'b0, cntEn)
   endtask

   task automatic t_sync();
      int n;
      // Synchronisation is turned on with the timer gate enable held low, so the timer counts on every rising edge.
      bus_wr(COL_OFS_SYNC_GATE, 8'h01);
      tOn <= 1'b1;
      tGate <= 1'b0;
      tick(SETTLE);
      `CHK("held until falling edge", 1'b0, syncC2)
      n = incs;
      runTo(1'b1);
      tick(SETTLE);
      `CHK("held over rising edge", 1'b0, syncC2)
      `CHK("increment on rising edge", n + 1, incs)
      runTo(1'b0);
      tick(SETTLE);
      `CHK("captured on falling edge", 1'b1, syncC2)
      bus_wr(COL_OFS_SYNC_GATE, 8'h00);
      c2 <= 1'b0;
      tOn <= 1'b0;
      tick(SETTLE);
      `CHK("passthrough again", 1'b0, syncC2)
   endtask

   task automatic t_latch();
      bus_wr(COL_OFS_LATCH_CTRL, 8'h09);
      tick(3);
      `CHK("set by pulse", 1'b1, q)
      `CHK("fixed reference enable", 1'b1, fixRef)
      chkRd(COL_OFS_LATCH_CTRL, 8'h01, "pulse bits cleared");
      bus_wr(COL_OFS_LATCH_CTRL, 8'h0c);
      tick(3);
      `CHK("both pulses reset", 1'b0, q)
      bus_wr(COL_OFS_LATCH_CTRL, 8'h08);
      bus_wr(COL_OFS_LATCH_CTRL, 8'h04);
      tick(3);
      `CHK("reset by pulse", 1'b0, q)
      c1 <= 1'b1;
      bus_wr(COL_OFS_LATCH_CTRL, 8'h20);
      tick(SETTLE);
      `CHK("set by first comparator", 1'b1, q)
      c1 <= 1'b0;
      tick(SETTLE);
      `CHK("level latch holds", 1'b1, q)
      c1 <= 1'b1;
      c2 <= 1'b1;
      bus_wr(COL_OFS_LATCH_CTRL, 8'h30);
      tick(SETTLE);
      `CHK("both comparators reset", 1'b0, q)
   endtask

   task automatic t_select();
      logic [1:0] s;
      c1 <= 1'b0;
      dir1 <= 1'b0;
      dir2 <= 1'b0;
      oe1 <= 1'b1;
      oe2 <= 1'b1;
      // With first output 0, second 1 and the latch set, each selection gives a distinct pair.
      for (int i = 0; i < 4; i++) begin
         s = i[1:0];
         bus_wr(COL_OFS_LATCH_CTRL, {s, 6'h08});
         tick(SETTLE);
         `CHK("pin one source", s[0], p1)
         `CHK("pin two source", ~s[1], p2)
         `CHK("pin two level", ~s[1], lvl2)
      end
      for (int j = 0; j < 4; j++) begin
         dir1 <= j[0];
         dir2 <= j[0];
         oe1 <= j[1];
         oe2 <= j[1];
         tick(3);
         `CHK("pin one drive", ~(~j[0] & j[1]), oeN1)
         `CHK("pin two drive", ~(~j[0] & j[1]), oeN2)
         `CHK("latch pin unchanged", 1'b1, p1)
      end
      chkRd(COL_OFS_LATCH_CTRL, 8'hc0, "selection kept");
      rst <= 1'b1;
      tick(4);
      rst <= 1'b0;
      tick(SETTLE);
      chkRd(COL_OFS_LATCH_CTRL, 8'h00, "selection after reset");
      `CHK("pin one plain comparator", 1'b0, p1)
      `CHK("pin two plain comparator", 1'b1, p2)
   endtask

   // Main sequence after 12 cycles of reset.
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      tick(1);
      t_regs();
      t_mirror();
      t_gate();
      t_sync();
      t_latch();
      t_select();
      testDone();
   end

   // The scenarios need well under a thousand cycles; a hang is cut off far beyond that.
   initial begin
      repeat (20000) @(posedge clk);
      badCount++;
      testDone();
   end
endmodule
